// [include/fprs_pkg.sv]
// shared constants and carriers for the fp rounding and operand select block
package fprs_pkg;

	// arithmetic control word fields
	localparam int AC_INEXACT_FLAG_POS = 20;
	localparam int AC_RMODE_LO_POS     = 30;
	localparam logic [31:0] AC_RESET_VAL = 32'h0000_0000;

	// rounding mode codes (field at bits 31:30)
	typedef enum logic [1:0] {
		RM_NEAREST = 2'h0,
		RM_DOWN    = 2'h1,
		RM_UP      = 2'h2,
		RM_ZERO    = 2'h3
	} fprs_rmode_t;

	// destination formats
	typedef enum logic [1:0] {
		FMT_SINGLE = 2'h0,
		FMT_DOUBLE = 2'h1,
		FMT_EXT    = 2'h2
	} fprs_fmt_t;

	// format geometry: fraction widths (explicit integer bit not counted for extended)
	localparam int SGL_FRAC_W = 23;
	localparam int DBL_FRAC_W = 52;
	localparam int EXT_FRAC_W = 63;
	localparam int EXP_W      = 15;
	localparam int SIG_W      = 64;
	localparam logic [14:0] SGL_EXP_MAX = 15'h00FE;
	localparam logic [14:0] DBL_EXP_MAX = 15'h07FE;
	localparam logic [14:0] EXT_EXP_MAX = 15'h7FFE;
	localparam logic [14:0] SGL_BIAS    = 15'h007F;
	localparam logic [14:0] DBL_BIAS    = 15'h03FF;
	localparam logic [14:0] EXT_BIAS    = 15'h3FFF;

	// operand register space: 16 global, 16 local, 4 floating point, 2 literals
	localparam int NUM_GREG = 16;
	localparam int NUM_LREG = 16;
	localparam int NUM_FREG = 4;
	localparam logic [5:0] SEL_LIT_ZERO = 6'h24;
	localparam logic [5:0] SEL_LIT_ONE  = 6'h25;
	localparam logic [5:0] SEL_FREG_BASE = 6'h20;
	localparam logic [79:0] EXT_PLUS_ONE = 80'h3FFF_8000_0000_0000_0000;

	// common three-register instruction word fields
	localparam int INS_OPC_POS  = 24;
	localparam int INS_DST_POS  = 19;
	localparam int INS_SRC2_POS = 14;
	localparam int INS_M2_POS   = 13;
	localparam int INS_M1_POS   = 11;
	localparam int INS_OPLO_POS = 7;
	localparam int INS_SRC1_POS = 0;
	localparam logic [7:0] REG_OPC_MIN = 8'h58;
	localparam logic [3:0] OPLO_LONG_BIT = 4'h1;

	// exact intermediate result handed to the rounder
	typedef struct packed {
		logic        sign;
		logic        is_nan;
		logic        is_inf;
		logic        is_zero;
		logic [16:0] exp;
		logic [66:0] sig;
	} fprs_exact_t;

	// rounded result
	typedef struct packed {
		logic        sign;
		logic [14:0] exp;
		logic [63:0] sig;
	} fprs_ext_t;

	// decoded instruction
	typedef struct packed {
		logic       valid;
		logic       is_long;
		logic       is_cmp;
		logic [5:0] src1;
		logic [5:0] src2;
		logic [5:0] dst;
	} fprs_dec_t;

endpackage

// [hw/fprs_decode.sv]
// decoder of the common three-register instruction word for fp operations
`timescale 1ns/1ns
module fprs_decode
	import fprs_pkg::*;
(
	// instruction
	input  wire logic [31:0] instr,
	// decoded fields
	output fprs_dec_t        dec
);

	function automatic logic [5:0] map_operand(input logic [4:0] f, input logic m);
		logic [5:0] r;
		r = {1'b0, f};
		if (m)
		begin
			if (f == 5'h00)
				r = SEL_LIT_ZERO;
			else if (f == 5'h10)
				r = SEL_LIT_ONE;
			else if (f < 5'h04)
				r = SEL_FREG_BASE + {4'h0, f[1:0]};
			else
				r = SEL_LIT_ZERO;
		end
		return r;
	endfunction

	logic [7:0] opc;
	logic [3:0] oplo;

	always_comb
	begin
		opc         = instr[INS_OPC_POS +: 8];
		oplo        = instr[INS_OPLO_POS +: 4];
		dec.valid   = (opc >= REG_OPC_MIN);
		dec.is_long = oplo[0] == OPLO_LONG_BIT[0];
		dec.is_cmp  = (oplo[3:1] == 3'h7);
		dec.src1    = map_operand(instr[INS_SRC1_POS +: 5], instr[INS_M1_POS]);
		dec.src2    = map_operand(instr[INS_SRC2_POS +: 5], instr[INS_M2_POS]);
		dec.dst     = map_operand(instr[INS_DST_POS +: 5], instr[INS_M2_POS + 1]);
	end

endmodule

// [hw/fprs_rounder.sv]
// single-step rounder from exact result to a destination format
`timescale 1ns/1ns
module fprs_rounder
	import fprs_pkg::*;
(
	// exact input
	input  fprs_exact_t      ex,
	input  fprs_rmode_t      rmode,
	input  fprs_fmt_t        fmt,
	// rounded output
	output fprs_ext_t        res,
	output logic             inexact
);

	function automatic logic [14:0] fmt_emax(input fprs_fmt_t f);
		unique case (f)
			// the exact exponent carries the extended bias, so rebias the format limit
			FMT_SINGLE: return SGL_EXP_MAX - SGL_BIAS + EXT_BIAS;
			FMT_DOUBLE: return DBL_EXP_MAX - DBL_BIAS + EXT_BIAS;
			default:    return EXT_EXP_MAX;
		endcase
	endfunction

	function automatic logic [6:0] fmt_keep(input fprs_fmt_t f);
		unique case (f)
			FMT_SINGLE: return 7'(SGL_FRAC_W + 1);
			FMT_DOUBLE: return 7'(DBL_FRAC_W + 1);
			default:    return 7'(EXT_FRAC_W + 1);
		endcase
	endfunction

	logic [66:0] mask_lo;
	logic [66:0] kept;
	logic [66:0] ulp;
	logic [67:0] summed;
	logic        guard;
	logic        sticky;
	logic        lsb;
	logic        up;
	logic        ovf;
	logic [16:0] e;
	logic [6:0]  drop;
	logic [14:0] emax;

	always_comb
	begin
		emax    = fmt_emax(fmt);
		drop    = 7'(67) - fmt_keep(fmt);
		mask_lo = (67'h1 << drop) - 67'h1;
		ulp     = 67'h1 << drop;
		kept    = ex.sig & ~mask_lo;
		guard   = |(ex.sig & (ulp >> 1));
		sticky  = |(ex.sig & (mask_lo >> 1));
		lsb     = |(ex.sig & ulp);
		// one rounding step straight from the exact value
		unique case (rmode)
			RM_UP:      up = !ex.sign && (guard || sticky);
			RM_DOWN:    up = ex.sign && (guard || sticky);
			RM_ZERO:    up = 1'b0;
			RM_NEAREST: up = guard && (sticky || lsb);
		endcase
		summed = {1'b0, kept} + (up ? {1'b0, ulp} : 68'h0);
		e      = ex.exp;
		if (summed[67])
		begin
			e      = ex.exp + 17'h1;
			summed = summed >> 1;
		end
		ovf     = !ex.is_nan && !ex.is_inf && !ex.is_zero && (e > {2'h0, emax});
		inexact = !ex.is_nan && !ex.is_inf && !ex.is_zero && (guard || sticky || ovf);
		res.sign = ex.sign;
		res.exp  = e[14:0];
		res.sig  = summed[66:3];
		if (ex.is_nan || ex.is_inf)
		begin
			// nan and infinity pass untouched by the mode
			res.exp = 15'h7FFF;
			res.sig = ex.is_nan ? (ex.sig[66:3] | 64'hC000_0000_0000_0000) : 64'h8000_0000_0000_0000;
		end
		else if (ex.is_zero)
		begin
			res.exp = 15'h0000;
			res.sig = 64'h0;
		end
		else if (ovf)
		begin
			// toward the nearer infinity or clamp to largest finite
			if (rmode == RM_NEAREST || (rmode == RM_UP && !ex.sign) || (rmode == RM_DOWN && ex.sign))
			begin
				res.exp = 15'h7FFF;
				res.sig = 64'h8000_0000_0000_0000;
			end
			else
			begin
				res.exp = emax;
				res.sig = ~mask_lo[66:3];
			end
		end
	end

endmodule

// [hw/fprs_core.sv]
// fp rounding and operand selection stage with arithmetic control word
//
// Function
// - set inexact flag when rounded differs
// - round by destination format and mode
// - round up gives nearest not below
// - round down gives nearest not above
// - truncate never grows the magnitude
// - nearest, ties go to even
// - positive overflow: inf or max finite
// - negative overflow: inf or max finite
// - mode ignored for compare, exact, nan
// - narrow destination from wide sources allowed
// - narrow destination rounds only once
// - decode common three-register instruction format
// - two literals: plus zero, plus one
// - globals, locals, fp registers 1 to 3 selectable
// - opcode picks 32 or 64 bit view
// - fp registers usable in both forms
// - mixed single and double not required
`timescale 1ns/1ns
module fprs_core
	import fprs_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        srst,
	// instruction and register file view
	input  wire logic        issue,
	input  wire logic [31:0] instr,
	input  wire logic [31:0] greg_rd [NUM_GREG],
	input  wire logic [31:0] lreg_rd [NUM_LREG],
	input  wire logic [79:0] freg_rd [NUM_FREG],
	// selected operands as extended values
	output fprs_ext_t        opnd1,
	output fprs_ext_t        opnd2,
	output logic             opnd_long,
	output logic [5:0]       dst_sel,
	output logic             opnd_valid,
	// exact result from arithmetic
	input  wire logic        res_valid,
	input  fprs_exact_t      res_exact,
	input  fprs_fmt_t        res_fmt,
	input  wire logic        res_is_cmp,
	// rounded result
	output fprs_ext_t        rnd_out,
	output logic             rnd_valid,
	// arithmetic control word access
	input  wire logic        ac_wr,
	input  wire logic [31:0] ac_wdata,
	output logic [31:0]      ac_word
);

	fprs_dec_t   dec;
	fprs_ext_t   rnd_res;
	logic        rnd_inexact;
	fprs_rmode_t rmode;
	logic [31:0] ac_ff;

	fprs_decode u_decode
	(
		.instr (instr),
		.dec   (dec)
	);

	assign rmode = fprs_rmode_t'(ac_ff[AC_RMODE_LO_POS +: 2]);

	fprs_rounder u_rounder
	(
		.ex      (res_exact),
		.rmode   (rmode),
		.fmt     (res_fmt), // any destination width, sources irrelevant
		.res     (rnd_res),
		.inexact (rnd_inexact)
	);

	// unpack a 32-bit single into extended form
	function automatic fprs_ext_t from_single(input logic [31:0] w);
		fprs_ext_t r;
		r.sign = w[31];
		if (w[30:23] == 8'h00)
		begin
			r.exp = 15'h0000;
			r.sig = {1'b0, w[22:0], 40'h0};
		end
		else if (w[30:23] == 8'hFF)
		begin
			r.exp = 15'h7FFF;
			r.sig = {1'b1, w[22:0], 40'h0};
		end
		else
		begin
			r.exp = {7'h00, w[30:23]} - SGL_BIAS + EXT_BIAS;
			r.sig = {1'b1, w[22:0], 40'h0};
		end
		return r;
	endfunction

	// unpack a 64-bit double into extended form
	function automatic fprs_ext_t from_double(input logic [63:0] w);
		fprs_ext_t r;
		r.sign = w[63];
		if (w[62:52] == 11'h000)
		begin
			r.exp = 15'h0000;
			r.sig = {1'b0, w[51:0], 11'h0};
		end
		else if (w[62:52] == 11'h7FF)
		begin
			r.exp = 15'h7FFF;
			r.sig = {1'b1, w[51:0], 11'h0};
		end
		else
		begin
			r.exp = {4'h0, w[62:52]} - DBL_BIAS + EXT_BIAS;
			r.sig = {1'b1, w[51:0], 11'h0};
		end
		return r;
	endfunction

	// read one 32-bit general register by operand index 0..31
	function automatic logic [31:0] greg_word(input logic [4:0] idx,
		input logic [31:0] g [NUM_GREG], input logic [31:0] l [NUM_LREG]);
		logic [31:0] v;
		v = idx[4] ? g[idx[3:0]] : l[idx[3:0]];
		return v;
	endfunction

	// select one operand; long form pairs an even register with the next
	function automatic fprs_ext_t pick(input logic [5:0] sel, input logic is_long,
		input logic [31:0] g [NUM_GREG], input logic [31:0] l [NUM_LREG],
		input logic [79:0] f [NUM_FREG]);
		fprs_ext_t   r;
		logic [4:0]  base;
		logic [4:0]  nxt;
		base = {sel[4:1], 1'b0};
		nxt  = {sel[4:1], 1'b1};
		if (sel == SEL_LIT_ZERO)
			r = '0;
		else if (sel == SEL_LIT_ONE)
			r = EXT_PLUS_ONE;
		else if (sel[5])
			r = f[sel[1:0]]; // extended value in either form
		else if (is_long)
			r = from_double({greg_word(nxt, g, l), greg_word(base, g, l)});
		else
			r = from_single(greg_word(sel[4:0], g, l));
		return r;
	endfunction

	// one width per instruction, so single and double never mix
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			opnd1      <= '0;
			opnd2      <= '0;
			opnd_long  <= 1'b0;
			dst_sel    <= 6'h00;
			opnd_valid <= 1'b0;
		end
		else
		begin
			opnd_valid <= issue && dec.valid;
			if (issue && dec.valid)
			begin
				opnd1     <= pick(dec.src1, dec.is_long, greg_rd, lreg_rd, freg_rd);
				opnd2     <= pick(dec.src2, dec.is_long, greg_rd, lreg_rd, freg_rd);
				opnd_long <= dec.is_long;
				dst_sel   <= dec.dst;
			end
		end
	end

	// rounded result register
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			rnd_out   <= '0;
			rnd_valid <= 1'b0;
		end
		else
		begin
			rnd_valid <= res_valid && !res_is_cmp;
			if (res_valid && !res_is_cmp)
				rnd_out <= rnd_res;
		end
	end

	logic set_inexact;
	assign set_inexact = res_valid && !res_is_cmp && rnd_inexact;

	// control word: a software write may clear the flag, but a same-cycle set wins
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			ac_ff <= AC_RESET_VAL;
		else
		begin
			if (ac_wr)
				ac_ff <= ac_wdata;
			if (set_inexact)
				ac_ff[AC_INEXACT_FLAG_POS] <= 1'b1;
		end
	end

	assign ac_word = ac_ff;

	// checks
	a_inexact_sets: assert property (@(posedge clk_sys) disable iff (srst)
		set_inexact |=> ac_ff[AC_INEXACT_FLAG_POS]) else $error("inexact flag not set");
	a_inexact_sticky: assert property (@(posedge clk_sys) disable iff (srst)
		ac_ff[AC_INEXACT_FLAG_POS] && !ac_wr |=> ac_ff[AC_INEXACT_FLAG_POS])
		else $error("inexact flag dropped");
	a_trunc_no_up: assert property (@(posedge clk_sys) disable iff (srst)
		res_valid && !res_is_cmp && rmode == RM_ZERO && !res_exact.is_nan && !res_exact.is_inf
		&& !res_exact.is_zero && res_exact.exp <= 17'h407E && res_exact.exp > 17'h0001
		|=> rnd_out.exp <= $past(res_exact.exp[14:0])) else $error("truncate grew magnitude");
	a_nan_passes: assert property (@(posedge clk_sys) disable iff (srst)
		res_valid && !res_is_cmp && res_exact.is_nan |=> rnd_out.exp == 15'h7FFF && rnd_valid)
		else $error("nan altered");
	a_exact_no_flag: assert property (@(posedge clk_sys) disable iff (srst)
		res_valid && res_exact.sig[2:0] == 3'h0 && res_fmt == FMT_EXT && res_exact.exp < 17'h7FFE
		|-> !rnd_inexact) else $error("exact result flagged");
	a_pos_ovf_up: assert property (@(posedge clk_sys) disable iff (srst)
		res_valid && !res_is_cmp && !res_exact.sign && !res_exact.is_nan && !res_exact.is_inf
		&& !res_exact.is_zero && res_exact.exp > {2'h0, u_rounder.emax} && (rmode == RM_UP || rmode == RM_NEAREST)
		|=> rnd_out.exp == 15'h7FFF && rnd_out.sig == 64'h8000_0000_0000_0000)
		else $error("positive overflow not infinity");
	a_neg_ovf_clamp: assert property (@(posedge clk_sys) disable iff (srst)
		res_valid && !res_is_cmp && res_exact.sign && !res_exact.is_nan && !res_exact.is_inf
		&& !res_exact.is_zero && res_exact.exp > {2'h0, u_rounder.emax} && (rmode == RM_UP || rmode == RM_ZERO)
		|=> rnd_out.exp == $past(u_rounder.emax) && rnd_out.sign) else $error("negative overflow not clamped");
	a_lit_one: assert property (@(posedge clk_sys) disable iff (srst)
		issue && dec.valid && dec.src1 == SEL_LIT_ONE |=> opnd1 == EXT_PLUS_ONE)
		else $error("literal one wrong");
	a_cmp_no_flag: assert property (@(posedge clk_sys) disable iff (srst)
		res_valid && res_is_cmp && !ac_wr && !ac_ff[AC_INEXACT_FLAG_POS] |=> !ac_ff[AC_INEXACT_FLAG_POS])
		else $error("compare touched inexact");

	c_round_inexact: cover property (@(posedge clk_sys) set_inexact);
	c_overflow: cover property (@(posedge clk_sys) res_valid && res_exact.exp > 17'h7FFF);
	c_long_issue: cover property (@(posedge clk_sys) issue && dec.valid && dec.is_long);
	c_set_and_clear: cover property (@(posedge clk_sys) set_inexact && ac_wr);

endmodule

// [testbench/testbench.sv]
// self-checking bench for the fp rounding and operand select stage
`timescale 1ns/1ns
module testbench
	import fprs_pkg::*;
;
	logic        clk_sys    = 1'b0;
	logic        srst       = 1'b1;
	logic        issue      = 1'b0;
	logic        res_valid  = 1'b0;
	logic        res_is_cmp = 1'b0;
	logic        ac_wr      = 1'b0;
	logic [31:0] instr      = 32'h0;
	logic [31:0] ac_wdata   = 32'h0;
	logic [31:0] greg_rd [NUM_GREG] = '{default: '0};
	logic [31:0] lreg_rd [NUM_LREG] = '{default: '0};
	logic [79:0] freg_rd [NUM_FREG] = '{default: '0};
	fprs_exact_t res_exact  = '0;
	fprs_fmt_t   res_fmt    = FMT_SINGLE;
	fprs_ext_t   opnd1;
	fprs_ext_t   opnd2;
	fprs_ext_t   rnd_out;
	logic        opnd_long;
	logic        opnd_valid;
	logic        rnd_valid;
	logic [5:0]  dst_sel;
	logic [31:0] ac_word;
	fprs_ext_t   q_rnd [$];
	fprs_ext_t   q_o1 [$];
	fprs_ext_t   q_o2 [$];
	logic        q_ol [$];
	logic [5:0]  q_dst [$];
	int          err_total   = 0;
	int          checks_done = 0;
	int          cyc         = 0;
	logic        flag_exp    = 1'b0;
	fprs_rmode_t mode        = RM_NEAREST;
	fprs_exact_t ex;
	logic [31:0] w;

	always #20 clk_sys = ~clk_sys;

	fprs_core DUT (.clk_sys, .srst, .issue, .instr, .greg_rd, .lreg_rd, .freg_rd, .opnd1, .opnd2,
		.opnd_long, .dst_sel, .opnd_valid, .res_valid, .res_exact, .res_fmt, .res_is_cmp, .rnd_out,
		.rnd_valid, .ac_wr, .ac_wdata, .ac_word);

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic cmp_val(string n, logic [79:0] e, logic [79:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cmp_bit(string n, logic e, logic g);
		cmp_val(n, 80'(e), 80'(g));
	endtask

	task automatic tick();
		@(posedge clk_sys);
		#2;
	endtask

	// reference rounding: one step from the exact value straight to the format
	function automatic fprs_ext_t ref_rnd(fprs_exact_t e, fprs_fmt_t f, output logic x);
		int          k;
		logic [64:0] kp;
		logic [66:0] lo;
		logic        rb;
		logic        st;
		logic        inc;
		logic        big;
		logic [16:0] xp;
		logic [16:0] lim;
		k = f == FMT_SINGLE ? 24 : f == FMT_DOUBLE ? 53 : 64;
		lim = f == FMT_SINGLE ? 17'h407E : f == FMT_DOUBLE ? 17'h43FE : 17'h7FFE;
		kp = 65'(e.sig >> (67 - k));
		rb = e.sig[66 - k];
		lo = e.sig << (k + 1);
		st = |lo;
		x = rb | st;
		inc = mode == RM_NEAREST ? rb & (st | kp[0]) : mode == RM_UP ? x & !e.sign : mode == RM_DOWN ? x & e.sign : 1'b0;
		kp = kp + 65'(inc);
		xp = e.exp;
		if (kp[k])
		begin
			kp = kp >> 1;
			xp = xp + 17'h1;
		end
		big = mode == RM_NEAREST || (mode == RM_UP && !e.sign) || (mode == RM_DOWN && e.sign);
		if (xp > lim)
		begin
			x = 1'b1;
			return big ? {e.sign, 15'h7FFF, 64'h8000_0000_0000_0000} : {e.sign, lim[14:0], ~64'h0 << (64 - k)};
		end
		return {e.sign, xp[14:0], 64'(kp << (64 - k))};
	endfunction

	// expected operand: literal, fp register or general register widened
	function automatic fprs_ext_t opv(logic [4:0] fld, logic m, logic lg);
		logic [4:0]  p;
		logic [31:0] lo;
		logic [31:0] hi;
		if (m)
			return fld == 5'h10 ? EXT_PLUS_ONE : (fld inside {1, 2, 3}) ? freg_rd[fld[1:0]] : 80'h0;
		p = lg ? {fld[4:1], 1'b0} : fld;
		lo = p[4] ? greg_rd[p[3:0]] : lreg_rd[p[3:0]];
		hi = p[4] ? greg_rd[p[3:0] + 4'h1] : lreg_rd[p[3:0] + 4'h1];
		if (!lg)
			return {lo[31], 15'(lo[30:23]) + 15'h3F80, 1'b1, lo[22:0], 40'h0};
		return {hi[31], 15'(hi[30:20]) + 15'h3C00, 1'b1, hi[19:0], lo, 11'h0};
	endfunction

	// expected destination select: register index, or literal / fp register code
	function automatic logic [5:0] dsel(logic [4:0] fld, logic m);
		if (!m)
			return {1'b0, fld};
		if (fld == 5'h10)
			return 6'h25;
		if (fld inside {1, 2, 3})
			return 6'h20 + 6'(fld);
		return 6'h24;
	endfunction

	function automatic fprs_exact_t mk(logic s, logic [16:0] x, logic [66:0] g);
		return {s, 3'b000, x, g};
	endfunction

	// a full write also clears the sticky flag, so each mode starts clean
	task automatic set_ac(logic [31:0] v);
		tick();
		ac_wr = 1'b1;
		ac_wdata = v;
		tick();
		ac_wr = 1'b0;
		flag_exp = v[AC_INEXACT_FLAG_POS];
		mode = fprs_rmode_t'(v[31:30]);
		cmp_val("ac_word", 80'(v), 80'(ac_word));
	endtask

	task automatic do_rnd(fprs_exact_t e, fprs_fmt_t f, logic c);
		fprs_ext_t r;
		logic      x;
		r = ref_rnd(e, f, x);
		tick();
		res_valid = 1'b1;
		res_exact = e;
		res_fmt = f;
		res_is_cmp = c;
		if (!c)
		begin
			q_rnd.push_back(r);
			flag_exp = flag_exp | x;
		end
		tick();
		res_valid = 1'b0;
		cmp_bit("inexact", flag_exp, ac_word[AC_INEXACT_FLAG_POS]);
	endtask

	task automatic do_op(logic [31:0] v);
		tick();
		issue = 1'b1;
		instr = v;
		if (v[31:24] >= REG_OPC_MIN)
		begin
			q_o1.push_back(opv(v[4:0], v[11], v[7]));
			q_o2.push_back(opv(v[18:14], v[13], v[7]));
			q_ol.push_back(v[7]);
			q_dst.push_back(dsel(v[23:19], v[14]));
		end
		tick();
		issue = 1'b0;
	endtask

	// a result pulse with nothing expected is a mismatch as well
	always @(posedge clk_sys)
	begin
		cyc++;
		if (rnd_valid !== 1'b0)
		begin
			if (q_rnd.size() == 0)
				cmp_bit("rnd_valid", 1'b0, rnd_valid);
			else
				cmp_val("rnd_out", q_rnd.pop_front(), rnd_out);
		end
		if (opnd_valid !== 1'b0)
		begin
			if (q_o1.size() == 0)
				cmp_bit("opnd_valid", 1'b0, opnd_valid);
			else
			begin
				cmp_val("opnd1", q_o1.pop_front(), opnd1);
				cmp_val("opnd2", q_o2.pop_front(), opnd2);
				cmp_bit("opnd_long", q_ol.pop_front(), opnd_long);
				cmp_val("dst_sel", 80'(q_dst.pop_front()), 80'(dst_sel));
			end
		end
		if (cyc > 5000)
		begin
			err_total++;
			report_and_stop();
		end
	end

	initial
	begin
		void'($urandom(90));
		foreach (greg_rd[i])
		begin
			greg_rd[i] = $urandom;
			greg_rd[i][30] = ~greg_rd[i][29];
			lreg_rd[i] = $urandom;
			lreg_rd[i][30] = ~lreg_rd[i][29];
		end
		foreach (freg_rd[i])
			freg_rd[i] = {16'($urandom), 32'($urandom), 32'($urandom)};
		repeat (6) @(posedge clk_sys);
		#2;
		srst = 1'b0;
		cmp_val("ac_word", 80'(AC_RESET_VAL), 80'(ac_word));
		do_op(32'h5800_6810);
		do_op(32'h5800_E080);
		repeat (40)
		begin
			w = $urandom;
			w[31:24] = 8'($urandom_range(88, 255));
			if (&w[10:8])
				w[10] = 1'b0;
			do_op(w);
		end
		repeat (4) do_op(32'($urandom_range(0, 32'h57FF_FFFF)));
		for (int m = 0; m < 4; m++)
		begin
			set_ac({2'(m), 30'h0});
			do_rnd(mk(1'b1, 17'h3FFF, 67'h4_0000_0000_0000_0000), FMT_SINGLE, 1'b0);
			do_rnd(mk(1'b0, 17'h3FFF, 67'h4_0000_0000_0000_0004), FMT_EXT, 1'b1);
			do_rnd(mk(1'b0, 17'h3FFF, 67'h4_0000_0000_0000_0004), FMT_EXT, 1'b0);
			do_rnd(mk(1'b1, 17'h3FFF, 67'h4_0000_0000_0000_000C), FMT_EXT, 1'b0);
			do_rnd(mk(1'b0, 17'h7FFE, 67'h7_FFFF_FFFF_FFFF_FFFF), FMT_EXT, 1'b0);
			do_rnd(mk(1'b1, 17'h7FFE, 67'h7_FFFF_FFFF_FFFF_FFFF), FMT_EXT, 1'b0);
			do_rnd(mk(1'b0, 17'h4100, 67'h4_0000_0000_0000_0001), FMT_SINGLE, 1'b0);
			do_rnd(mk(1'b1, 17'h4100, 67'h4_0000_0000_0000_0001), FMT_SINGLE, 1'b0);
			do_rnd(mk(1'b0, 17'h3FFF, 67'h4_0000_0000_0000_0000), FMT_DOUBLE, 1'b0);
			repeat (12)
			begin
				ex = mk(1'($urandom), 17'h3FF0 + 17'($urandom_range(0, 31)),
					{1'b1, 2'($urandom), 32'($urandom), 32'($urandom)});
				do_rnd(ex, fprs_fmt_t'($urandom_range(0, 2)), 1'b0);
			end
		end
		tick();
		report_and_stop();
	end
endmodule
